// ===== common/sas_pkg.sv
// =====================================================================
// Shared constants and types
// =====================================================================
package sas_pkg;

  // =====================================================================
  // Clocking and conversion timing
  // =====================================================================
  localparam int SYS_CLK_KHZ = 40000;
  localparam int ADC_CLK_MAX_KHZ = 14508;
  // Divide rounds up so the converter clock never exceeds its limit
  localparam int CONV_DIV = (SYS_CLK_KHZ + ADC_CLK_MAX_KHZ - 1) /
                            ADC_CLK_MAX_KHZ;
  localparam int CONV_CLKS_MIN = 18;
  localparam int RES_BITS = 12;
  localparam int SMP_MIN = CONV_CLKS_MIN - RES_BITS;
  localparam int SMP_W = 4;

  // =====================================================================
  // Channels and buffering
  // =====================================================================
  localparam int N_SEQ = 8;
  localparam int N_CH = 9;
  localparam logic [3:0] TEMP_CH = 4'h8;
  localparam int FIFO_DEPTH = 8;

  // =====================================================================
  // Register offsets (byte addresses) and region codes (address bits 7:6)
  // =====================================================================
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CHEN = 8'h04;
  localparam logic [7:0] A_FWCMD = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_RANGE = 8'h10;
  localparam logic [1:0] A_SMP_REGION = 2'h1;
  localparam logic [1:0] A_RES_REGION = 2'h2;

  // =====================================================================
  // Field positions and reset values
  // =====================================================================
  localparam int CTRL_EN = 0;
  localparam int CTRL_FW = 1;
  localparam int CTRL_STREAM = 2;
  localparam int CTRL_REF = 3;
  localparam int FWCMD_GO = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RANGE = 1;
  localparam int STAT_PWR = 2;
  localparam int STAT_CHAN = 3;
  localparam int RANGE_HI = 16;
  localparam int RES_NEW = 31;
  localparam logic [11:0] RANGE_LO_RST = 12'h000;
  localparam logic [11:0] RANGE_HI_RST = 12'hfff;
  localparam logic [7:0] CHEN_RST = 8'h00;
  localparam logic [3:0] SMP_RST = 4'h0;

  // =====================================================================
  // Types
  // =====================================================================
  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_SAMPLE = 2'b01,
    SAS_CONVERT = 2'b10
  } sas_state_t;

  typedef enum logic [1:0] {
    SAS_REF_VDD = 2'b00,
    SAS_REF_VDD_HALF = 2'b01,
    SAS_REF_BANDGAP = 2'b10,
    SAS_REF_EXT = 2'b11
  } sas_ref_t;

  typedef struct packed {
    logic [3:0] chan;
    logic [11:0] value;
  } sas_result_t;

  typedef struct packed {
    sas_ref_t ref_sel;
    logic [3:0] chan_sel;
    logic sample;
    logic [11:0] dac_code;
  } sas_afe_t;

endpackage : sas_pkg

// ===== rtl/sas_fifo.sv
`timescale 1ns/1ps
// =====================================================================
// Result FIFO with valid/ready on both sides
// =====================================================================
module sas_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full_w;
  logic empty_w;

  // Extra pointer bit tells full from empty
  assign full_w = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                  (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty_w = (wr_ptr_r == rd_ptr_r);
  assign in_ready = !full_w;
  assign out_valid = !empty_w;
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];

  // Storage
  always_ff @(posedge clk_sys)
  begin
    if (in_valid && !full_w)
    begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (in_valid && !full_w)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (out_ready && !empty_w)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule : sas_fifo

// ===== rtl/sas_seq.sv
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module sas_seq (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Analog front end
  input wire logic power_ok,
  input wire logic cmp_in,
  output sas_pkg::sas_afe_t afe,
  // Result stream
  output logic res_valid,
  input wire logic res_ready,
  output sas_pkg::sas_result_t res_data,
  // Range event
  output logic range_flag
);
  // =====================================================================
  // Declarations
  // =====================================================================
  sas_pkg::sas_state_t state_r;
  logic [1:0] div_r;
  logic tick_w;
  logic [31:0] ctrl_r;
  logic [7:0] chen_r;
  logic [11:0] lo_r;
  logic [11:0] hi_r;
  logic [3:0] smp_r [sas_pkg::N_CH];
  logic [11:0] res_mem_r [sas_pkg::N_CH];
  logic [8:0] res_new_r;
  logic [3:0] chan_r;
  logic [4:0] smp_cnt_r;
  logic [3:0] bit_r;
  logic [11:0] sar_r;
  logic [11:0] final_w;
  logic done_w;
  logic fw_go_w;
  logic auto_w;
  logic room_w;
  logic oor_w;
  logic clr_range_w;
  logic fifo_ready_w;
  logic [3:0] next_w;
  logic [3:0] ridx_w;
  sas_pkg::sas_result_t push_w;

  // Next enabled channel after cur, wrapping round
  function automatic logic [3:0] next_chan(input logic [7:0] en,
                                           input logic [3:0] cur);
    logic [3:0] c;
    next_chan = cur;
    for (int i = 1; i <= sas_pkg::N_SEQ; i++)
    begin
      c = 4'((int'(cur) + i) % sas_pkg::N_SEQ);
      if (en[c[2:0]] && next_chan == cur)
      begin
        next_chan = c;
      end
    end
    if (en[cur[2:0]] == 1'b0 && next_chan == cur)
    begin
      next_chan = 4'h0;
    end
  endfunction : next_chan

  // =====================================================================
  // Converter clock enable
  // =====================================================================
  // Divide rounds up, so the enable never beats the converter limit
  always_ff @(posedge clk_sys)
  begin
    if (reset || div_r == 2'(sas_pkg::CONV_DIV - 1))
    begin
      div_r <= 2'h0;
    end
    else
    begin
      div_r <= div_r + 2'h1;
    end
  end
  assign tick_w = (div_r == 2'(sas_pkg::CONV_DIV - 1));

  // =====================================================================
  // Register writes
  // =====================================================================
  assign fw_go_w = reg_wr && reg_addr == sas_pkg::A_FWCMD &&
                   reg_wdata[sas_pkg::FWCMD_GO];
  assign clr_range_w = reg_wr && reg_addr == sas_pkg::A_STAT &&
                       reg_wdata[sas_pkg::STAT_RANGE];

  // Control, enables and limits
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_r <= 32'h0000_0000;
      chen_r <= sas_pkg::CHEN_RST;
      lo_r <= sas_pkg::RANGE_LO_RST;
      hi_r <= sas_pkg::RANGE_HI_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == sas_pkg::A_CTRL)
      begin
        ctrl_r <= {27'h0, reg_wdata[4:0]};
      end
      if (reg_addr == sas_pkg::A_CHEN)
      begin
        chen_r <= reg_wdata[7:0];
      end
      if (reg_addr == sas_pkg::A_RANGE)
      begin
        lo_r <= reg_wdata[11:0];
        hi_r <= reg_wdata[sas_pkg::RANGE_HI +: 12];
      end
    end
  end

  // Per-channel sample times
  genvar g;
  generate
    for (g = 0; g < sas_pkg::N_CH; g++)
    begin : g_smp
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          smp_r[g] <= sas_pkg::SMP_RST;
        end
        else if (reg_wr && reg_addr[7:6] == sas_pkg::A_SMP_REGION &&
                 reg_addr[5:2] == 4'(g))
        begin
          smp_r[g] <= reg_wdata[3:0];
        end
      end
    end
  endgenerate

  // =====================================================================
  // Sequencer
  // =====================================================================
  assign auto_w = ctrl_r[sas_pkg::CTRL_EN] && !ctrl_r[sas_pkg::CTRL_FW] &&
                  (chen_r != 8'h00);
  assign next_w = next_chan(chen_r, chan_r);
  // Sampling waits for FIFO room, so a push at the end never drops
  assign room_w = !ctrl_r[sas_pkg::CTRL_STREAM] || fifo_ready_w;
  assign final_w = cmp_in ? sar_r : (sar_r & ~(12'h001 << bit_r));
  assign done_w = state_r == sas_pkg::SAS_CONVERT && tick_w &&
                  bit_r == 4'h0;

  // Scan state
  always_ff @(posedge clk_sys)
  begin
    if (reset || !power_ok)
    begin
      state_r <= sas_pkg::SAS_IDLE;
      chan_r <= 4'h0;
      smp_cnt_r <= 5'h00;
    end
    else
    begin
      unique case (state_r)
        sas_pkg::SAS_IDLE:
        begin
          if (ctrl_r[sas_pkg::CTRL_FW] && ctrl_r[sas_pkg::CTRL_EN] &&
              fw_go_w && reg_wdata[3:0] <= sas_pkg::TEMP_CH)
          begin
            chan_r <= reg_wdata[3:0];
            smp_cnt_r <= 5'(sas_pkg::SMP_MIN) + 5'(smp_r[reg_wdata[3:0]]);
            state_r <= sas_pkg::SAS_SAMPLE;
          end
          else if (auto_w)
          begin
            chan_r <= next_w;
            smp_cnt_r <= 5'(sas_pkg::SMP_MIN) + 5'(smp_r[next_w]);
            state_r <= sas_pkg::SAS_SAMPLE;
          end
        end
        sas_pkg::SAS_SAMPLE:
        begin
          if (tick_w && room_w)
          begin
            smp_cnt_r <= smp_cnt_r - 5'h01;
            if (smp_cnt_r == 5'h01)
            begin
              state_r <= sas_pkg::SAS_CONVERT;
            end
          end
        end
        sas_pkg::SAS_CONVERT:
        begin
          if (done_w && auto_w)
          begin
            // Next channel samples at once: no idle slot
            chan_r <= next_w;
            smp_cnt_r <= 5'(sas_pkg::SMP_MIN) + 5'(smp_r[next_w]);
            state_r <= sas_pkg::SAS_SAMPLE;
          end
          else if (done_w)
          begin
            state_r <= sas_pkg::SAS_IDLE;
          end
        end
        default:
        begin
          state_r <= sas_pkg::SAS_IDLE;
        end
      endcase
    end
  end

  // Successive approximation, one bit per converter clock
  always_ff @(posedge clk_sys)
  begin
    if (reset || state_r != sas_pkg::SAS_CONVERT)
    begin
      bit_r <= 4'(sas_pkg::RES_BITS - 1);
      sar_r <= 12'h800;
    end
    else if (tick_w && bit_r != 4'h0)
    begin
      bit_r <= bit_r - 4'h1;
      sar_r <= final_w | (12'h001 << (bit_r - 4'h1));
    end
  end

  // =====================================================================
  // Results, range check and stream
  // =====================================================================
  assign oor_w = final_w < lo_r || final_w > hi_r;
  assign ridx_w = reg_addr[5:2];

  always_ff @(posedge clk_sys)
  begin
    if (done_w)
    begin
      res_mem_r[chan_r] <= final_w;
    end
  end

  // New-result flags: a fresh result beats a clearing read
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      res_new_r <= 9'h000;
    end
    else
    begin
      for (int i = 0; i < sas_pkg::N_CH; i++)
      begin
        if (done_w && chan_r == 4'(i))
        begin
          res_new_r[i] <= 1'b1;
        end
        else if (reg_rd && reg_addr[7:6] == sas_pkg::A_RES_REGION &&
                 ridx_w == 4'(i))
        begin
          res_new_r[i] <= 1'b0;
        end
      end
    end
  end

  // Sticky out-of-range flag; set wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      range_flag <= 1'b0;
    end
    else if (done_w && oor_w)
    begin
      range_flag <= 1'b1;
    end
    else if (clr_range_w)
    begin
      range_flag <= 1'b0;
    end
  end

  assign push_w = '{chan: chan_r, value: final_w};

  sas_fifo #(
    .WIDTH($bits(sas_pkg::sas_result_t)),
    .DEPTH(sas_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(done_w && ctrl_r[sas_pkg::CTRL_STREAM]),
    .in_ready(fifo_ready_w),
    .in_data(push_w),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  // =====================================================================
  // Analog controls and read port
  // =====================================================================
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      afe <= '0;
    end
    else
    begin
      afe.ref_sel <= sas_pkg::sas_ref_t'(ctrl_r[sas_pkg::CTRL_REF +: 2]);
      afe.chan_sel <= chan_r;
      afe.sample <= state_r == sas_pkg::SAS_SAMPLE;
      afe.dac_code <= sar_r;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (reset || !reg_rd)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_addr[7:6] == sas_pkg::A_SMP_REGION && ridx_w < 4'h9)
    begin
      reg_rdata <= {28'h000_0000, smp_r[ridx_w]};
    end
    else if (reg_addr[7:6] == sas_pkg::A_RES_REGION && ridx_w < 4'h9)
    begin
      reg_rdata <= {res_new_r[ridx_w], 19'h0_0000, res_mem_r[ridx_w]};
    end
    else
    begin
      unique case (reg_addr)
        sas_pkg::A_CTRL: reg_rdata <= ctrl_r;
        sas_pkg::A_CHEN: reg_rdata <= {24'h00_0000, chen_r};
        sas_pkg::A_STAT: reg_rdata <= {25'h000_0000, chan_r, power_ok,
                                       range_flag,
                                       state_r != sas_pkg::SAS_IDLE};
        sas_pkg::A_RANGE: reg_rdata <= {4'h0, hi_r, 4'h0, lo_r};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // =====================================================================
  // Checks
  // =====================================================================
  logic [5:0] len_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset || (state_r == sas_pkg::SAS_IDLE) || done_w)
    begin
      len_r <= 6'h00;
    end
    else if (tick_w && len_r != 6'h3f)
    begin
      len_r <= len_r + 6'h01;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_conv_len_min: assert property (done_w |-> len_r >= 6'h11)
    else $error("conversion shorter than 18 converter clocks");
  a_tick_rate: assert property (tick_w |=>
      !tick_w ##1 !tick_w ##1 tick_w)
    else $error("converter clock enable too fast");
  a_ref_follow: assert property (##1 afe.ref_sel ==
      $past(ctrl_r[sas_pkg::CTRL_REF +: 2]))
    else $error("reference select does not follow control");
  a_sample_load: assert property (
      $rose(state_r == sas_pkg::SAS_SAMPLE)
      |-> smp_cnt_r == 5'(sas_pkg::SMP_MIN) + 5'(smp_r[chan_r]))
    else $error("sample time not taken from channel setting");
  a_scan_enabled: assert property (
      state_r == sas_pkg::SAS_SAMPLE && !ctrl_r[sas_pkg::CTRL_FW]
      |-> chen_r[chan_r[2:0]])
    else $error("scan converted a disabled channel");
  a_no_idle_gap: assert property (
      done_w && auto_w && power_ok |=> state_r == sas_pkg::SAS_SAMPLE)
    else $error("idle slot between scan conversions");
  a_result_store: assert property (done_w |=>
      res_mem_r[$past(chan_r)] == $past(final_w))
    else $error("result not stored in channel buffer");
  a_range_set: assert property (done_w && oor_w |=> range_flag)
    else $error("out-of-range result did not raise flag");
  a_range_hold: assert property (range_flag &&
      !clr_range_w |=> range_flag)
    else $error("range flag dropped without clear");
  a_power_off: assert property (!power_ok |=>
      state_r == sas_pkg::SAS_IDLE)
    else $error("converter active without high-speed clock");

  c_auto_scan: cover property (done_w && auto_w ##[1:100] done_w);
  c_fw_temp: cover property (done_w && chan_r == sas_pkg::TEMP_CH);
  c_range_hit: cover property ($rose(range_flag));
  c_fifo_full: cover property (!fifo_ready_w);

endmodule : sas_seq

// ===== verif/sas_afe_model.sv
`timescale 1ns/1ps
// ====
// Analog inputs, temperature sensor and comparator
// ====
module sas_afe_model (
  // Clock
  input wire logic clk_sys,
  // Front end controls
  input wire sas_pkg::sas_afe_t afe,
  input wire logic [8:0][11:0] lvl,
  // Comparator
  output logic cmp_in
);
  logic [11:0] held;

  // Track the chosen input while the window is open, hold it after
  always @(posedge clk_sys)
  begin
    if (afe.sample === 1'b1 && afe.chan_sel <= 4'h8)
    begin
      held <= lvl[afe.chan_sel];
    end
  end

  // Ideal comparator; offset and noise are not modelled
  assign cmp_in = (held >= afe.dac_code);
endmodule : sas_afe_model

// ===== verif/tb.sv
`timescale 1ns/1ps
// ====
// Bench for the converter sequencer
// ====
module tb;
  // Design inputs
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic power_ok = 1'b1;
  logic res_ready = 1'b0;
  // Design outputs and partner
  logic cmp_in;
  logic [31:0] reg_rdata;
  logic res_valid;
  logic range_flag;
  sas_pkg::sas_afe_t afe;
  sas_pkg::sas_result_t res_data;
  logic [8:0][11:0] lvl;
  // Bookkeeping
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int smp_cyc = 0;
  logic [31:0] rd;

  // Input levels; channel 8 is the temperature sensor
  assign lvl = {12'h05a, 12'h7fe, 12'h987, 12'h654, 12'h321,
                12'h789, 12'h456, 12'h123, 12'ha00};

  // Clock, cycle count and open-window count
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (afe.sample === 1'b1)
      smp_cyc <= smp_cyc + 1;
  end

  sas_seq uut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_ok(power_ok), .cmp_in(cmp_in),
    .afe(afe), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data), .range_flag(range_flag));
  sas_afe_model far (.clk_sys(clk_sys), .afe(afe), .lvl(lvl),
    .cmp_in(cmp_in));

  // ====
  // Shared tasks
  // ====
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // A wait that ran out counts against the run and stops it
  task give_up;
    check_val(32'h0000_0000, 32'h0000_0001);
    finish_test();
  endtask : give_up

  // Strobes last one cycle; read data stands the cycle after
  task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : reg_read

  // One firmware conversion; polls the channel buffer, result in rd
  task fw_one(input logic [3:0] ch);
    int k;
    // A go is refused while busy, and a stale new flag would end the poll
    for (k = 0; k < 200; k++)
    begin
      reg_read(sas_pkg::A_STAT, rd);
      if (rd[sas_pkg::STAT_BUSY] === 1'b0)
        break;
    end
    if (k == 200)
      give_up();
    reg_read(8'h80 + {2'b00, ch, 2'b00}, rd);
    reg_write(sas_pkg::A_FWCMD, {28'h000_0001, ch});
    for (k = 0; k < 200; k++)
    begin
      reg_read(8'h80 + {2'b00, ch, 2'b00}, rd);
      if (rd[31] === 1'b1)
        break;
    end
    if (k == 200)
      give_up();
  endtask : fw_one

  // Take one stream entry and note the cycle it showed up
  task pop(output sas_pkg::sas_result_t r, output int t);
    int k;
    for (k = 0; k < 400; k++)
    begin
      @(negedge clk_sys);
      if (res_valid === 1'b1)
        break;
    end
    if (k == 400)
      give_up();
    r = res_data;
    t = cyc;
    @(posedge clk_sys);
    res_ready <= 1'b1;
    @(posedge clk_sys);
    res_ready <= 1'b0;
  endtask : pop

  task drain(output int n, output logic [3:0] first);
    sas_pkg::sas_result_t r;
    int t;
    n = 0;
    first = 4'hf;
    repeat (20)
    begin
      @(negedge clk_sys);
      if (res_valid !== 1'b1)
        break;
      pop(r, t);
      if (n == 0)
        first = r.chan;
      n++;
    end
  endtask : drain

  // ====
  // Scenarios
  // ====
  task t_reset;
    @(negedge clk_sys);
    check_val(32'({afe, range_flag, res_valid}), 32'h0000_0000);
    reg_read(sas_pkg::A_CHEN, rd);
    check_val(rd, 32'h0000_0000);
    reg_read(sas_pkg::A_RANGE, rd);
    check_val(rd, 32'h0fff_0000);
    reg_read(8'h54, rd);
    check_val(rd, 32'h0000_0000);
    reg_read(sas_pkg::A_STAT, rd);
    check_val(rd, 32'h0000_0004);
    reg_write(8'hfc, 32'hffff_ffff);
    reg_read(8'hfc, rd);
    check_val(rd, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  // Every channel and reference in firmware mode, own window each
  task t_fw;
    int s0;
    int w;
    for (int i = 0; i < 9; i++)
    begin
      reg_write(sas_pkg::A_CTRL, (32'(i % 4) << 3) | 32'h0000_0003);
      reg_write(8'h40 + 8'(4 * i), 32'(i));
      check_val(32'(afe.ref_sel), 32'(i % 4));
      s0 = smp_cyc;
      fw_one(4'(i));
      check_val(32'(rd[11:0]), 32'(lvl[i]));
      w = (smp_cyc - s0) / sas_pkg::CONV_DIV;
      check_val(32'(w == 5 + i || w == 6 + i), 32'h0000_0001);
      reg_write(8'h40 + 8'(4 * i), 32'h0000_0000);
    end
    reg_read(8'h80, rd);
    check_val(32'(rd[31]), 32'h0000_0000);
    $display("test firmware done");
  endtask : t_fw

  // Scan over 0, 2, 7 with the stream on; it resumes after channel 8
  task t_scan;
    sas_pkg::sas_result_t r;
    int t0;
    int t1;
    int n;
    logic [3:0] f;
    logic [15:0] order;
    order = 16'h2072;
    t0 = 0;
    reg_write(sas_pkg::A_RANGE, 32'h07ff_0000);
    reg_write(sas_pkg::A_CHEN, 32'h0000_0085);
    reg_write(sas_pkg::A_CTRL, 32'h0000_0005);
    for (int k = 0; k < 4; k++)
    begin
      pop(r, t1);
      check_val(32'(r), 32'({order[4*k +: 4], lvl[order[4*k +: 4]]}));
      check_val(32'(range_flag), 32'(k >= 2));
      if (k != 0)
        check_val(32'(t1 - t0 >= 51 && t1 - t0 <= 62), 32'h0000_0001);
      t0 = t1;
    end
    reg_write(sas_pkg::A_CTRL, 32'h0000_0000);
    drain(n, f);
    reg_read(8'h9c, rd);
    check_val(rd & 32'h8000_0fff, 32'h8000_07fe);
    reg_write(sas_pkg::A_STAT, 32'h0000_0002);
    reg_write(sas_pkg::A_RANGE, 32'h0fff_0000);
    $display("test scan done");
  endtask : t_scan

  // Limits 0x100..0x800: above, inside, clear, below
  task t_range;
    reg_write(sas_pkg::A_RANGE, 32'h0800_0100);
    reg_write(sas_pkg::A_CTRL, 32'h0000_0003);
    fw_one(4'h0);
    check_val(32'(range_flag), 32'h0000_0001);
    fw_one(4'h2);
    check_val(32'(range_flag), 32'h0000_0001);
    reg_read(sas_pkg::A_STAT, rd);
    check_val(32'(rd[1]), 32'h0000_0001);
    reg_write(sas_pkg::A_STAT, 32'h0000_0002);
    @(negedge clk_sys);
    check_val(32'(range_flag), 32'h0000_0000);
    fw_one(4'h8);
    check_val(32'(range_flag), 32'h0000_0001);
    reg_write(sas_pkg::A_STAT, 32'h0000_0002);
    reg_write(sas_pkg::A_RANGE, 32'h0fff_0000);
    $display("test range done");
  endtask : t_range

  // No fast clock: a go must open no window and leave the block idle
  task t_power;
    int s0;
    @(posedge clk_sys);
    power_ok <= 1'b0;
    reg_write(sas_pkg::A_CTRL, 32'h0000_0003);
    s0 = smp_cyc;
    reg_write(sas_pkg::A_FWCMD, 32'h0000_0013);
    repeat (100) @(posedge clk_sys);
    reg_read(sas_pkg::A_STAT, rd);
    check_val(rd & 32'h0000_0007, 32'h0000_0000);
    check_val(32'(smp_cyc - s0), 32'h0000_0000);
    @(posedge clk_sys);
    power_ok <= 1'b1;
    fw_one(4'h3);
    check_val(32'(rd[11:0]), 32'h0000_0789);
    $display("test power done");
  endtask : t_power

  // Far side stalls until the buffer refuses, then drains it
  task t_fifo;
    int n;
    logic [3:0] f;
    reg_write(sas_pkg::A_CHEN, 32'h0000_0006);
    reg_write(sas_pkg::A_CTRL, 32'h0000_0005);
    repeat (800) @(posedge clk_sys);
    check_val(32'(res_valid), 32'h0000_0001);
    reg_write(sas_pkg::A_CTRL, 32'h0000_0000);
    drain(n, f);
    check_val(32'(n), 32'(sas_pkg::FIFO_DEPTH));
    check_val(32'(f), 32'h0000_0001);
    $display("test fifo done");
  endtask : t_fifo

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_fw();
    t_scan();
    t_range();
    t_power();
    t_fifo();
    finish_test();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    give_up();
  end
endmodule : tb
